// ===== src/xmn_pkg.sv
// constants for the extended message negotiator
package xmn_pkg;
    // ============================================================
    // message bytes
    localparam logic [7:0] MSG_EXT = 8'h01;
    localparam logic [7:0] MSG_REJECT = 8'h07;
    localparam logic [7:0] EXT_SDTR = 8'h01;
    localparam logic [7:0] EXT_WDTR = 8'h03;
    localparam logic [7:0] LEN_SDTR = 8'h03;
    localparam logic [7:0] LEN_WDTR = 8'h02;
    localparam logic [7:0] WIDTH_8 = 8'h00;
    localparam logic [8:0] LEN_ZERO_COUNT = 9'h100;
    // ============================================================
    // timing figures
    localparam logic [7:0] PERIOD_MIN = 8'h19;
    localparam logic [7:0] PERIOD_MAX = 8'he3;
    localparam logic [7:0] OFFSET_UNLIM = 8'hff;
    localparam logic [1:0] NS_PER_FACTOR_SH = 2'h2;
    localparam int NBANDS = 15;
    localparam logic [7:0] BAND_TOP [NBANDS] = '{
        8'h19, 8'h1f, 8'h25, 8'h2b, 8'h32, 8'h3e, 8'h4b, 8'h56,
        8'h64, 8'h70, 8'h7d, 8'h93, 8'hb2, 8'hc8, 8'he3};
    localparam logic [3:0] BAND_NONE = 4'hf;
    // ============================================================
    // reset values
    localparam logic [7:0] RST_PERIOD = 8'h00;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_WIDTH = 8'h00;
    // ============================================================
    // parser states and reply kinds
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LEN = 3'h1,
        ST_CODE = 3'h3,
        ST_ARG = 3'h2,
        ST_SEND = 3'h6,
        ST_HOLD = 3'h7
    } xmn_state_e;
    typedef enum logic [1:0] {
        RP_SDTR = 2'h0,
        RP_WDTR = 2'h1,
        RP_REJ = 2'h2
    } xmn_reply_e;
endpackage

// ===== src/xmn_negotiator.sv
// target-side extended message parser and transfer negotiator
`timescale 1ns/1ps
`default_nettype none
module xmn_negotiator #(
    parameter int N_INIT = 8,
    parameter int ID_W = 3,
    parameter logic [7:0] MAX_OFFSET = 8'h0f
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic RESET_COND,
    input wire logic BUS_DEV_RESET,
    input wire logic [ID_W-1:0] INIT_ID,
    input wire logic MSG_OUT_VALID,
    input wire logic [7:0] MSG_OUT_BYTE,
    input wire logic MSG_IN_READY,
    output logic MSG_IN_VALID,
    output logic [7:0] MSG_IN_BYTE,
    output logic MSG_IN_LAST,
    input wire logic REPLY_DONE,
    input wire logic ATN_REJECT,
    input wire logic ATN_PARITY,
    input wire logic SEND_SYNC_EN,
    input wire logic NEG_START,
    input wire logic DATA_PHASE,
    output logic SYNC_ACTIVE,
    output logic [7:0] SYNC_PERIOD,
    output logic [7:0] SYNC_OFFSET,
    output logic [9:0] PERIOD_NS,
    output logic [3:0] RATE_BAND,
    output logic [7:0] WIDTH_EXP,
    output logic WIDE_NEEDED,
    output logic NEG_BUSY
);
    // ============================================================
    // parameter checks
    initial begin
        if (N_INIT > (1 << ID_W) || N_INIT < 1)
            $error("N_INIT does not fit ID_W");
        if (MAX_OFFSET == 8'h00)
            $error("MAX_OFFSET must be nonzero");
    end

    // ============================================================
    // state
    xmn_pkg::xmn_state_e state_r;
    xmn_pkg::xmn_reply_e kind_r;
    logic [8:0] cnt_r;
    logic [7:0] code_r;
    logic [7:0] len_r;
    logic [7:0] arg0_r;
    logic [1:0] aidx_r;
    logic [7:0] reply_r [5];
    logic [2:0] rlen_r;
    logic [2:0] ridx_r;
    logic dev_orig_r;
    logic [7:0] pend_per_r;
    logic [7:0] pend_off_r;
    logic [7:0] per_tab_r [N_INIT];
    logic [7:0] off_tab_r [N_INIT];
    logic [7:0] wid_tab_r [N_INIT];
    logic [N_INIT-1:0] wide_need_r;
    logic clear_all;
    logic commit;
    logic cancel;
    logic last_arg;
    logic send_last;
    logic [7:0] resp_per;
    logic [7:0] resp_off;
    logic code_ok;

    // ============================================================
    // combinational helpers
    assign clear_all = RESET_COND | BUS_DEV_RESET;
    assign last_arg = (state_r == xmn_pkg::ST_ARG) && MSG_OUT_VALID &&
        (cnt_r == 9'h001);
    assign send_last = MSG_IN_VALID && MSG_IN_READY && MSG_IN_LAST;
    // supported code with the length it needs
    assign code_ok = (MSG_OUT_BYTE == xmn_pkg::EXT_SDTR &&
        len_r == xmn_pkg::LEN_SDTR) ||
        (MSG_OUT_BYTE == xmn_pkg::EXT_WDTR &&
        len_r == xmn_pkg::LEN_WDTR);
    // responder raises period and lowers offset as needed
    always_comb begin
        resp_per = arg0_r;
        if (arg0_r < xmn_pkg::PERIOD_MIN)
            resp_per = xmn_pkg::PERIOD_MIN;
        resp_off = (MSG_OUT_BYTE > MAX_OFFSET) ? MAX_OFFSET :
            MSG_OUT_BYTE; // offset byte is on the bus at last_arg
        if (arg0_r > xmn_pkg::PERIOD_MAX)
            resp_off = 8'h00; // too slow for any band: async
    end
    // commit on accepted reply, cancel on error messages
    assign commit = (state_r == xmn_pkg::ST_HOLD) && REPLY_DONE &&
        !dev_orig_r && !ATN_REJECT && !ATN_PARITY;
    assign cancel = ((state_r == xmn_pkg::ST_HOLD) &&
        (ATN_REJECT || ATN_PARITY || (REPLY_DONE && dev_orig_r))) ||
        (send_last && kind_r == xmn_pkg::RP_REJ && dev_orig_r);

    // ============================================================
    // message parser and reply sequencer
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= xmn_pkg::ST_IDLE;
            kind_r <= xmn_pkg::RP_REJ;
            cnt_r <= 9'h000;
            code_r <= 8'h00;
            len_r <= 8'h00;
            arg0_r <= 8'h00;
            aidx_r <= 2'h0;
            ridx_r <= 3'h0;
            rlen_r <= 3'h0;
            dev_orig_r <= 1'b0;
            for (int i = 0; i < 5; i++)
                reply_r[i] <= 8'h00;
        end else if (clear_all) begin
            state_r <= xmn_pkg::ST_IDLE;
            dev_orig_r <= 1'b0;
        end else begin
            case (state_r)
                xmn_pkg::ST_IDLE: begin
                    dev_orig_r <= 1'b0;
                    if (MSG_OUT_VALID &&
                        MSG_OUT_BYTE == xmn_pkg::MSG_EXT) begin
                        state_r <= xmn_pkg::ST_LEN;
                    end else if (NEG_START && SEND_SYNC_EN) begin
                        dev_orig_r <= 1'b1;
                        kind_r <= xmn_pkg::RP_SDTR;
                        reply_r[0] <= xmn_pkg::MSG_EXT;
                        reply_r[1] <= xmn_pkg::LEN_SDTR;
                        reply_r[2] <= xmn_pkg::EXT_SDTR;
                        reply_r[3] <= xmn_pkg::PERIOD_MIN;
                        reply_r[4] <= MAX_OFFSET;
                        rlen_r <= 3'h5;
                        ridx_r <= 3'h0;
                        state_r <= xmn_pkg::ST_SEND;
                    end
                end
                xmn_pkg::ST_LEN: if (MSG_OUT_VALID) begin
                    len_r <= MSG_OUT_BYTE;
                    cnt_r <= (MSG_OUT_BYTE == 8'h00) ?
                        xmn_pkg::LEN_ZERO_COUNT :
                        {1'b0, MSG_OUT_BYTE};
                    state_r <= xmn_pkg::ST_CODE;
                end
                xmn_pkg::ST_CODE: if (MSG_OUT_VALID) begin
                    code_r <= MSG_OUT_BYTE;
                    cnt_r <= cnt_r - 9'h001;
                    aidx_r <= 2'h0;
                    if (code_ok) begin
                        state_r <= xmn_pkg::ST_ARG;
                    end else begin
                        kind_r <= xmn_pkg::RP_REJ;
                        reply_r[0] <= xmn_pkg::MSG_REJECT;
                        rlen_r <= 3'h1;
                        ridx_r <= 3'h0;
                        state_r <= xmn_pkg::ST_SEND;
                    end
                end
                xmn_pkg::ST_ARG: if (MSG_OUT_VALID) begin
                    cnt_r <= cnt_r - 9'h001;
                    aidx_r <= aidx_r + 2'h1;
                    if (aidx_r == 2'h0)
                        arg0_r <= MSG_OUT_BYTE;
                    if (last_arg)
                        state_r <= xmn_pkg::ST_SEND;
                    if (last_arg && code_r == xmn_pkg::EXT_WDTR) begin
                        kind_r <= xmn_pkg::RP_WDTR;
                        reply_r[0] <= xmn_pkg::MSG_EXT;
                        reply_r[1] <= xmn_pkg::LEN_WDTR;
                        reply_r[2] <= xmn_pkg::EXT_WDTR;
                        reply_r[3] <= xmn_pkg::WIDTH_8;
                        rlen_r <= 3'h4;
                        ridx_r <= 3'h0;
                        dev_orig_r <= 1'b0;
                    end else if (last_arg && dev_orig_r) begin
                        // initiator answered our request: check it
                        if (arg0_r < xmn_pkg::PERIOD_MIN ||
                            MSG_OUT_BYTE > MAX_OFFSET) begin
                            kind_r <= xmn_pkg::RP_REJ;
                            reply_r[0] <= xmn_pkg::MSG_REJECT;
                            rlen_r <= 3'h1;
                            ridx_r <= 3'h0;
                        end else begin
                            state_r <= xmn_pkg::ST_IDLE;
                        end
                    end else if (last_arg) begin
                        kind_r <= xmn_pkg::RP_SDTR;
                        reply_r[0] <= xmn_pkg::MSG_EXT;
                        reply_r[1] <= xmn_pkg::LEN_SDTR;
                        reply_r[2] <= xmn_pkg::EXT_SDTR;
                        reply_r[3] <= resp_per;
                        reply_r[4] <= resp_off;
                        rlen_r <= 3'h5;
                        ridx_r <= 3'h0;
                    end
                end
                xmn_pkg::ST_SEND: if (MSG_IN_READY) begin
                    ridx_r <= MSG_IN_LAST ? 3'h0 : ridx_r + 3'h1;
                    if (MSG_IN_LAST)
                        state_r <= (kind_r == xmn_pkg::RP_REJ) ?
                            xmn_pkg::ST_IDLE : xmn_pkg::ST_HOLD;
                end
                xmn_pkg::ST_HOLD: begin
                    if (ATN_PARITY) begin
                        ridx_r <= 3'h0;
                        state_r <= xmn_pkg::ST_SEND;
                    end else if (ATN_REJECT || REPLY_DONE) begin
                        state_r <= xmn_pkg::ST_IDLE;
                    end else if (dev_orig_r && MSG_OUT_VALID &&
                        MSG_OUT_BYTE == xmn_pkg::MSG_EXT) begin
                        state_r <= xmn_pkg::ST_LEN;
                    end
                end
                default: state_r <= xmn_pkg::ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // reply byte outputs
    assign MSG_IN_VALID = (state_r == xmn_pkg::ST_SEND);
    assign MSG_IN_BYTE = reply_r[ridx_r];
    assign MSG_IN_LAST = MSG_IN_VALID && (ridx_r == rlen_r - 3'h1);
    assign NEG_BUSY = (state_r != xmn_pkg::ST_IDLE);

    // ============================================================
    // pending values of the reply being sent
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pend_per_r <= xmn_pkg::RST_PERIOD;
            pend_off_r <= xmn_pkg::RST_OFFSET;
        end else if (last_arg && code_r == xmn_pkg::EXT_SDTR &&
            !dev_orig_r) begin
            pend_per_r <= resp_per;
            pend_off_r <= resp_off;
        end
    end

    // ============================================================
    // per-initiator agreement tables
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < N_INIT; i++) begin
                per_tab_r[i] <= xmn_pkg::RST_PERIOD;
                off_tab_r[i] <= xmn_pkg::RST_OFFSET;
                wid_tab_r[i] <= xmn_pkg::RST_WIDTH;
            end
            wide_need_r <= '1;
        end else if (clear_all) begin
            for (int i = 0; i < N_INIT; i++) begin
                off_tab_r[i] <= xmn_pkg::RST_OFFSET;
                wid_tab_r[i] <= xmn_pkg::RST_WIDTH;
            end
            wide_need_r <= '1;
        end else begin
            if (commit && kind_r == xmn_pkg::RP_SDTR) begin
                per_tab_r[INIT_ID] <= pend_per_r;
                off_tab_r[INIT_ID] <= pend_off_r;
            end else if (commit && kind_r == xmn_pkg::RP_WDTR) begin
                wid_tab_r[INIT_ID] <= xmn_pkg::WIDTH_8;
                wide_need_r[INIT_ID] <= 1'b0;
            end else if (cancel) begin
                off_tab_r[INIT_ID] <= 8'h00;
            end else if (last_arg && dev_orig_r &&
                code_r == xmn_pkg::EXT_SDTR && arg0_r >=
                xmn_pkg::PERIOD_MIN && MSG_OUT_BYTE <= MAX_OFFSET) begin
                per_tab_r[INIT_ID] <= arg0_r;
                off_tab_r[INIT_ID] <= MSG_OUT_BYTE;
            end
        end
    end

    // ============================================================
    // rate band lookup
    function automatic logic [3:0] band_of(input logic [7:0] f);
        logic [3:0] b;
        b = xmn_pkg::BAND_NONE;
        for (int i = xmn_pkg::NBANDS - 1; i >= 0; i--)
            if (f <= xmn_pkg::BAND_TOP[i])
                b = 4'(i);
        return b;
    endfunction

    // ============================================================
    // agreement seen by the transfer engine
    assign SYNC_PERIOD = per_tab_r[INIT_ID];
    assign SYNC_OFFSET = off_tab_r[INIT_ID]; // limits, not targets
    assign WIDTH_EXP = wid_tab_r[INIT_ID];
    assign WIDE_NEEDED = wide_need_r[INIT_ID];
    assign SYNC_ACTIVE = DATA_PHASE && (SYNC_OFFSET != 8'h00);
    assign PERIOD_NS = {2'b00, SYNC_PERIOD} <<
        xmn_pkg::NS_PER_FACTOR_SH;
    assign RATE_BAND = band_of(SYNC_PERIOD);

    // ============================================================
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    sequence s_sdtr_head;
        MSG_IN_VALID && ridx_r == 3'h0 && kind_r == xmn_pkg::RP_SDTR;
    endsequence

    a_sync_data_only: assert property (
        SYNC_ACTIVE |-> DATA_PHASE)
        else $error("sync outside data phase");
    a_reset_async: assert property (
        clear_all |=> SYNC_OFFSET == 8'h00 && !NEG_BUSY)
        else $error("agreement kept after reset");
    a_len_zero: assert property (
        state_r == xmn_pkg::ST_LEN && MSG_OUT_VALID &&
        MSG_OUT_BYTE == 8'h00 && !clear_all |=> cnt_r == 9'h100)
        else $error("zero length not 256");
    a_reject_code: assert property (
        state_r == xmn_pkg::ST_CODE && MSG_OUT_VALID && !code_ok &&
        !clear_all |=> MSG_IN_VALID && MSG_IN_BYTE == 8'h07)
        else $error("bad code not rejected");
    a_sdtr_header: assert property (
        s_sdtr_head |-> MSG_IN_BYTE == 8'h01 && rlen_r == 3'h5)
        else $error("bad sync header");
    a_reply_period: assert property (
        MSG_IN_VALID && kind_r == xmn_pkg::RP_SDTR && ridx_r == 3'h3
        |-> MSG_IN_BYTE >= 8'h19)
        else $error("reply period too short");
    a_width_zero: assert property (
        MSG_IN_VALID && kind_r == xmn_pkg::RP_WDTR && ridx_r == 3'h3
        |-> MSG_IN_BYTE == 8'h00 && MSG_IN_LAST)
        else $error("width reply not zero");
    a_dev_start_en: assert property (
        state_r == xmn_pkg::ST_IDLE && !MSG_OUT_VALID && NEG_START &&
        !SEND_SYNC_EN |=> state_r == xmn_pkg::ST_IDLE)
        else $error("negotiation started while disabled");
    a_parity_resend: assert property (
        state_r == xmn_pkg::ST_HOLD && ATN_PARITY && !clear_all
        |=> s_sdtr_head or (MSG_IN_VALID && ridx_r == 3'h0))
        else $error("reply not resent after parity error");
    a_reject_cancel: assert property (
        state_r == xmn_pkg::ST_HOLD && ATN_REJECT && !clear_all &&
        $stable(INIT_ID) ##1 $stable(INIT_ID) |-> SYNC_OFFSET == 8'h00)
        else $error("reject did not cancel sync");
endmodule
`default_nettype wire

// ===== testbench/xmn_initiator_model.sv
// initiator model: sends message bytes and answers the reply handshake
`timescale 1ns/1ps
`default_nettype none
module xmn_initiator_model (
    input wire logic MCLK,
    output logic MSG_OUT_VALID,
    output logic [7:0] MSG_OUT_BYTE,
    output logic MSG_IN_READY,
    input wire logic MSG_IN_VALID,
    input wire logic [7:0] MSG_IN_BYTE,
    input wire logic MSG_IN_LAST,
    output logic REPLY_DONE,
    output logic ATN_REJECT,
    output logic ATN_PARITY
);
    logic [8:0] got [$];
    // idle levels at time zero
    initial begin
        MSG_OUT_VALID = 1'b0;
        MSG_OUT_BYTE = 8'h00;
        MSG_IN_READY = 1'b0;
        ATN_PARITY = 1'b0;
        ATN_REJECT = 1'b0;
        REPLY_DONE = 1'b0;
    end
    // ============================================================
    // message out, first byte 01h then count, code, arguments
    task automatic msg(input int n, input logic [39:0] m);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge MCLK);
            #1;
            MSG_OUT_VALID = 1'b1;
            MSG_OUT_BYTE = m[8*i+:8];
            @(posedge MCLK);
            #1;
            MSG_OUT_VALID = 1'b0;
            MSG_OUT_BYTE = ~m[8*i+:8]; // released byte does not linger
        end
    endtask
    // ============================================================
    // message in, optional stall, then take bytes up to the last one
    task automatic recv(input int stall);
        int k;
        got.delete();
        repeat (stall) @(posedge MCLK);
        #1;
        MSG_IN_READY = 1'b1;
        k = 0;
        while (k < 40 && !(got.size() > 0 && got[$][8] === 1'b1)) begin
            @(negedge MCLK);
            if (MSG_IN_VALID === 1'b1)
                got.push_back({MSG_IN_LAST, MSG_IN_BYTE});
            @(posedge MCLK);
            k++;
        end
        #1;
        MSG_IN_READY = 1'b0;
    endtask
    // one-cycle outcome: 0 done, 1 reject, 2 parity error
    task automatic pulse(input int which);
        @(posedge MCLK);
        #1;
        REPLY_DONE = (which == 0);
        ATN_REJECT = (which == 1);
        ATN_PARITY = (which == 2);
        @(posedge MCLK);
        #1;
        REPLY_DONE = 1'b0;
        ATN_REJECT = 1'b0;
        ATN_PARITY = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the extended message negotiator
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk;
    logic nrst;
    logic reset_cond;
    logic bus_dev_reset;
    logic send_sync_en;
    logic neg_start;
    logic data_phase;
    logic msg_out_valid;
    logic msg_in_ready;
    logic reply_done;
    logic atn_reject;
    logic atn_parity;
    logic msg_in_valid;
    logic msg_in_last;
    logic sync_active;
    logic wide_needed;
    logic neg_busy;
    logic [2:0] init_id;
    logic [7:0] msg_out_byte;
    logic [7:0] msg_in_byte;
    logic [7:0] sync_period;
    logic [7:0] sync_offset;
    logic [7:0] width_exp;
    logic [9:0] period_ns;
    logic [3:0] rate_band;
    int err_count;
    int checked;
    logic [35:0] tbl [5] = '{36'h10_20_19_0f_0, 36'h1a_08_1a_08_1,
        36'h40_ff_40_0f_6, 36'he3_01_e3_01_e, 36'he4_05_e4_00_f};
    logic [7:0] bad [6] = '{8'h00, 8'h02, 8'h04, 8'h7f, 8'h80, 8'hff};
    xmn_negotiator #(.N_INIT(8), .ID_W(3), .MAX_OFFSET(8'h0f))
        xmn_negotiator_i (
        .MCLK(mclk), .NRST(nrst), .RESET_COND(reset_cond),
        .BUS_DEV_RESET(bus_dev_reset), .INIT_ID(init_id),
        .MSG_OUT_VALID(msg_out_valid), .MSG_OUT_BYTE(msg_out_byte),
        .MSG_IN_READY(msg_in_ready), .MSG_IN_VALID(msg_in_valid),
        .MSG_IN_BYTE(msg_in_byte), .MSG_IN_LAST(msg_in_last),
        .REPLY_DONE(reply_done), .ATN_REJECT(atn_reject),
        .ATN_PARITY(atn_parity), .SEND_SYNC_EN(send_sync_en),
        .NEG_START(neg_start), .DATA_PHASE(data_phase),
        .SYNC_ACTIVE(sync_active), .SYNC_PERIOD(sync_period),
        .SYNC_OFFSET(sync_offset), .PERIOD_NS(period_ns),
        .RATE_BAND(rate_band), .WIDTH_EXP(width_exp),
        .WIDE_NEEDED(wide_needed), .NEG_BUSY(neg_busy));
    xmn_initiator_model ini_i (.MCLK(mclk), .MSG_OUT_VALID(msg_out_valid),
        .MSG_OUT_BYTE(msg_out_byte), .MSG_IN_READY(msg_in_ready),
        .MSG_IN_VALID(msg_in_valid), .MSG_IN_BYTE(msg_in_byte),
        .MSG_IN_LAST(msg_in_last), .REPLY_DONE(reply_done),
        .ATN_REJECT(atn_reject), .ATN_PARITY(atn_parity));
    // ============================================================
    // clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #800000;
        err_count++;
        end_of_test();
    end
    // ============================================================
    // helpers
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reply(input int n, input logic [39:0] e);
        chk("reply count", 16'(ini_i.got.size()), 16'(n));
        for (int i = 0; i < n && i < ini_i.got.size(); i++) begin
            chk("reply byte", {7'h00, ini_i.got[i]},
                {7'h00, i == n - 1, e[8*(n-1-i)+:8]});
        end
    endtask
    // one-cycle strobe: 0 start request, 1 device reset, 2 reset condition
    task automatic strobe(input int which);
        @(posedge mclk);
        #1;
        neg_start = (which == 0);
        bus_dev_reset = (which == 1);
        reset_cond = (which == 2);
        @(posedge mclk);
        #1;
        neg_start = 1'b0;
        bus_dev_reset = 1'b0;
        reset_cond = 1'b0;
    endtask
    // initiator-started exchange, reply checked, then committed
    task automatic sdtr(input logic [7:0] p, o, ep, eo, input logic [3:0] b);
        ini_i.msg(5, {8'h01, 8'h03, 8'h01, p, o});
        ini_i.recv(2);
        reply(5, {8'h01, 8'h03, 8'h01, ep, eo});
        ini_i.pulse(0);
        chk("offset", 16'(sync_offset), 16'(eo));
        chk("period", 16'(sync_period), 16'(ep));
        chk("period ns", 16'(period_ns), 16'(ep) * 16'h4);
        chk("band", 16'(rate_band), 16'(b));
    endtask
    task automatic end_of_test;
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ============================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        reset_cond = 1'b0;
        bus_dev_reset = 1'b0;
        send_sync_en = 1'b0;
        neg_start = 1'b0;
        data_phase = 1'b0;
        init_id = 3'h0;
        err_count = 0;
        checked = 0;
        repeat (5) @(posedge mclk);
        #1;
        nrst = 1'b1;
        chk("rst offset", 16'(sync_offset), 16'h0);
        chk("rst wide", {wide_needed, width_exp}, 16'h100);
        foreach (tbl[i]) begin
            sdtr(tbl[i][35:28], tbl[i][27:20], tbl[i][19:12], tbl[i][11:4],
                 tbl[i][3:0]);
        end
        sdtr(8'h40, 8'h08, 8'h40, 8'h08, 4'h6);
        chk("async outside data", 16'(sync_active), 16'h0);
        @(posedge mclk);
        #1;
        data_phase = 1'b1;
        @(negedge mclk);
        chk("sync in data", 16'(sync_active), 16'h1);
        @(posedge mclk);
        #1;
        init_id = 3'h1;
        @(negedge mclk);
        chk("other id", 16'(sync_offset), 16'h0);
        chk("other id sync", 16'(sync_active), 16'h0);
        @(posedge mclk);
        #1;
        init_id = 3'h0;
        @(negedge mclk);
        chk("own id", 16'(sync_offset), 16'h8);
        // parity error after our reply, then resend and restore
        ini_i.msg(5, {8'h01, 8'h03, 8'h01, 8'h40, 8'h08});
        ini_i.recv(0);
        ini_i.pulse(2);
        chk("parity cancels", 16'(sync_offset), 16'h0);
        ini_i.recv(1);
        reply(5, {8'h01, 8'h03, 8'h01, 8'h40, 8'h08});
        ini_i.pulse(0);
        chk("restored", 16'(sync_offset), 16'h8);
        ini_i.msg(5, {8'h01, 8'h03, 8'h01, 8'h40, 8'h08});
        ini_i.recv(0);
        ini_i.pulse(1);
        chk("reject cancels", {7'h00, neg_busy, sync_offset}, 16'h0);
        // unsupported and reserved codes, and a zero count
        foreach (bad[i]) begin
            ini_i.msg(3, {8'h01, 8'h03, bad[i]});
            ini_i.recv(0);
            reply(1, 40'h07);
        end
        ini_i.msg(3, {8'h01, 8'h00, 8'h01});
        ini_i.recv(0);
        reply(1, 40'h07);
        ini_i.msg(1, 40'h08);
        chk("non extended", 16'(neg_busy), 16'h0);
        // width exchange always settles on eight bits
        ini_i.msg(4, {8'h01, 8'h02, 8'h03, 8'h02});
        ini_i.recv(1);
        reply(4, 40'h01020300);
        ini_i.pulse(0);
        chk("width", {wide_needed, width_exp}, 16'h000);
        // device-started negotiation, disabled then enabled
        strobe(0);
        chk("start disabled", 16'(neg_busy), 16'h0);
        send_sync_en = 1'b1;
        strobe(0);
        ini_i.recv(1);
        reply(5, 40'h010301190f);
        ini_i.msg(5, 40'h0103013006);
        @(posedge mclk);
        #1;
        chk("adopted", {sync_period, sync_offset}, 16'h3006);
        // request left unanswered drops the link to async
        strobe(0);
        ini_i.recv(0);
        ini_i.pulse(0);
        chk("no answer", {7'h00, neg_busy, sync_offset}, 16'h0);
        strobe(0);
        ini_i.recv(0);
        ini_i.msg(5, 40'h0103013006);
        chk("readopted", 16'(sync_offset), 16'h6);
        strobe(0);
        ini_i.recv(0);
        ini_i.msg(5, 40'h0103013020);
        ini_i.recv(0);
        reply(1, 40'h07);
        ini_i.pulse(0);
        chk("voided", 16'(sync_offset), 16'h0);
        // both reset sources drop the agreement and flag width
        sdtr(8'h40, 8'h08, 8'h40, 8'h08, 4'h6);
        strobe(1);
        chk("dev reset", {wide_needed, sync_offset}, 16'h100);
        sdtr(8'h40, 8'h08, 8'h40, 8'h08, 4'h6);
        strobe(2);
        chk("reset cond", {wide_needed, sync_offset}, 16'h100);
        // power-on reset in mid-run clears period as well
        sdtr(8'h40, 8'h08, 8'h40, 8'h08, 4'h6);
        @(posedge mclk);
        #1;
        nrst = 1'b0;
        @(posedge mclk);
        #1;
        nrst = 1'b1;
        chk("power on", 16'(sync_offset), 16'h0);
        chk("power on period", 16'(sync_period), 16'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
